// File: fms_pkg.sv
// Purpose: Shared constants and types for the formatter microsequencer core.
// Assumes: 16-bit program words, 10-bit program counter, 8-bit data path.
// Notes:   Instruction fields and the operation set are decoded in fms_core.
package fms_pkg;

  localparam int PC_W      = 10;
  localparam int INSTR_W   = 16;
  localparam int DATA_W    = 8;
  localparam int SCR_DEPTH = 16;
  localparam int SCR_AW    = 4;
  localparam int OUT_N     = 16;
  localparam int IN_N      = 8;
  localparam int MUX_N     = 16;

  // Field positions inside the program word.
  localparam int CTL_LSB    = 12;
  localparam int SEL_BIT    = 11;
  localparam int FN_LSB     = 8;
  localparam int MUXSEL_LSB = 10;

  // Reset values.
  localparam logic [PC_W-1:0]   PC_RESET  = 10'h000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;

  // Jump test multiplexer inputs and selects.
  localparam logic [3:0] MUX_ZERO     = 4'h0;
  localparam logic [3:0] MUX_TAPE_END = 4'ha;
  localparam logic [3:0] SEL_ALWAYS   = 4'hf;

  // Strobe and scratch pad assignments used by the firmware.
  localparam logic [3:0]        OUT_TIMEBASE  = 4'hc;
  localparam logic [2:0]        IN_WRCMD      = 3'h7;
  localparam logic [3:0]        SCR_WRCMD     = 4'h0;
  localparam logic [3:0]        SCR_DLY_LO    = 4'h1;
  localparam logic [3:0]        SCR_DLY_HI    = 4'h2;
  localparam int                WRCMD_FWD_BIT = 0;
  localparam logic [DATA_W-1:0] WRCMD_MASK    = 8'h3f;

  // Time base preset for a 10 us unit at the 75 ips reference speed.
  localparam logic [DATA_W-1:0] TB_PRESET_10US = 8'hd0;

  typedef enum logic [2:0] {
    FN_CLR,
    FN_OR,
    FN_AND,
    FN_XOR,
    FN_ADD,
    FN_SUB,
    FN_PASS_A,
    FN_SET
  } fms_alu_fn_t;

  typedef enum logic [3:0] {
    OP_IMM_FMT,
    OP_IMM_SCR,
    OP_ACC_FMT,
    OP_ACC_SCR,
    OP_TEST,
    OP_ALU_IMM,
    OP_IN_FMT,
    OP_IN_SCR,
    OP_JUMP,
    OP_CALL,
    OP_RET
  } fms_op_t;

endpackage

// File: fms_alu_if.sv
// Purpose: Carries operands, function and result between core and ALU.
// Assumes: Purely combinational path.
// Notes:   The core drives the operands, the ALU returns result and zero.
`timescale 1ns/1ps
interface fms_alu_if;
  logic [fms_pkg::DATA_W-1:0] a;
  logic [fms_pkg::DATA_W-1:0] b;
  logic [fms_pkg::DATA_W-1:0] r;
  fms_pkg::fms_alu_fn_t       fn;
  logic                       zero;

  modport core (output a, output b, output fn, input r, input zero);
  modport alu  (input a, input b, input fn, output r, output zero);
endinterface

// File: fms_alu.sv
// Purpose: Eight-function ALU with zero detect on the result.
// Assumes: A is the accumulator, B the data bus operand.
// Notes:   Combinational; the core latches result and zero flag.
`timescale 1ns/1ps
module fms_alu (
  // Operand and result bundle
  fms_alu_if.alu bus
);

  always_comb
  begin
    case (bus.fn)
      fms_pkg::FN_CLR:    bus.r = '0;
      fms_pkg::FN_OR:     bus.r = bus.a | bus.b;
      fms_pkg::FN_AND:    bus.r = bus.a & bus.b;
      fms_pkg::FN_XOR:    bus.r = bus.a ^ bus.b;
      fms_pkg::FN_ADD:    bus.r = bus.a + bus.b;
      fms_pkg::FN_SUB:    bus.r = bus.a - bus.b;
      fms_pkg::FN_PASS_A: bus.r = bus.a;
      default:            bus.r = '1;
    endcase
    // Zero detect sees every result bit.
    bus.zero = (bus.r == '0);
  end

endmodule // fms_alu

// File: fms_core.sv
// Purpose: Instruction fetch, decode and execute for the formatter
//          microsequencer.
// Assumes: Asynchronous program ROM read; formatter logic on the same clock.
// Notes:   One instruction per clock, fetched one cycle ahead of execution.
//
// Overview of operation
// - Eleven operations in three classes: transfer, ALU and branch.
// - Transfers go to a numbered output strobe or a scratch location.
// - Immediate byte goes to the bus with strobe, or into scratch.
// - Accumulator goes to the bus, to formatter or scratch by variant.
// - ALU operand comes from immediate, input strobe or scratch pad.
// - ALU gets bus on B, accumulator on A; test ops keep accumulator.
// - Clear zeroes the accumulator; a following OR loads the operand.
// - Zero flag asserts when every ALU result bit is zero.
// - Zero flag is latched on the clock after the ALU operation.
// - Conditional jump takes the target only if the selected input is true.
// - Unconditional jump and call always go to the target.
// - Call saves the return address in one register; nesting overwrites.
// - Return reloads the program counter from the return register.
// - One test input reflects the end of tape marker.
// - Write command byte on input strobe seven; bit 0 is forward.
// - Masked write command byte is kept in scratch location zero.
// - Output strobe twelve presets the time base; delay in S1, S2.
// - Preset 208 gives a 10 us unit at the reference speed.
// - Taken jump or return extends load pulse and blocks next step.
// - Scratch pad holds 16 words of 8 bits.
// - Selector bit routes strobes to scratch pad or strobe decoders.
`timescale 1ns/1ps
module fms_core (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // Program ROM
  output logic [fms_pkg::PC_W-1:0]          rom_addr,
  input  wire logic [fms_pkg::INSTR_W-1:0]  rom_data,
  // Formatter data bus and strobes
  output logic [fms_pkg::DATA_W-1:0]        fmt_data,
  output logic [fms_pkg::OUT_N-1:0]         out_strobe,
  output logic [fms_pkg::IN_N-1:0]          in_strobe,
  input  wire logic [fms_pkg::DATA_W-1:0]   fmt_in_data,
  // Jump test inputs
  input  wire logic [fms_pkg::MUX_N-1:0]    test_in,
  input  wire logic                         tape_end_test_input,
  // Status
  output logic                              load_jump_address,
  output logic                              zero_flag,
  output logic [fms_pkg::DATA_W-1:0]        acc_bits,
  output logic                              timebase_tick,
  output logic [2*fms_pkg::DATA_W-1:0]      delay_count,
  output logic                              write_cmd_fwd
);

  typedef struct packed {
    logic [fms_pkg::PC_W-1:0]                             pc;
    logic [fms_pkg::INSTR_W-1:0]                          ir;
    logic [fms_pkg::PC_W-1:0]                             ir_pc;
    logic                                                 ir_vld;
    logic                                                 load_jump_address_ext;
    logic [fms_pkg::DATA_W-1:0]                           acc;
    logic                                                 zero;
    logic [fms_pkg::PC_W-1:0]                             ret;
    logic [fms_pkg::SCR_DEPTH-1:0][fms_pkg::DATA_W-1:0]   scr;
    logic [fms_pkg::DATA_W-1:0]                           fdata;
    logic [fms_pkg::OUT_N-1:0]                            ostb;
    logic [fms_pkg::DATA_W-1:0]                           tb_pre;
    logic [fms_pkg::DATA_W-1:0]                           tb_cnt;
    logic                                                 tb_tick;
  } fms_state_t;

  fms_state_t q;
  fms_state_t d;

  fms_alu_if alu_if ();

  fms_alu u_alu (
    .bus (alu_if.alu)
  );

  function automatic fms_pkg::fms_op_t decode(
    input logic [fms_pkg::INSTR_W-1:0] w
  );
    logic sel;
    sel = w[fms_pkg::SEL_BIT];
    // The selector bit steers transfers to scratch pad or strobes.
    casez (w[15:12])
      4'b0000: decode = fms_pkg::OP_TEST;
      4'b0001: decode = fms_pkg::OP_RET;
      4'b001?: decode = sel ? fms_pkg::OP_ACC_SCR : fms_pkg::OP_ACC_FMT;
      4'b0100: decode = fms_pkg::OP_ALU_IMM;
      4'b0101: decode = sel ? fms_pkg::OP_IN_SCR : fms_pkg::OP_IN_FMT;
      4'b011?: decode = sel ? fms_pkg::OP_IMM_SCR : fms_pkg::OP_IMM_FMT;
      4'b10??: decode = fms_pkg::OP_JUMP;
      default: decode = fms_pkg::OP_CALL;
    endcase
  endfunction

  function automatic logic [15:0] onehot16(input logic [3:0] i);
    onehot16 = 16'h0001 << i;
  endfunction

  fms_pkg::fms_op_t           op;
  logic                       exec;
  logic [3:0]                 xfer_addr;
  logic [3:0]                 alu_addr;
  logic [3:0]                 mux_sel;
  logic [fms_pkg::MUX_N-1:0]  test_vec;
  logic                       is_branch;
  logic                       taken;
  logic [fms_pkg::DATA_W-1:0] db;
  logic                       alu_class;
  logic                       to_fmt;
  logic                       tb_preset;
  logic [15:0]                in_hot;

  always_comb
  begin
    op        = decode(q.ir);
    exec      = q.ir_vld && !q.load_jump_address_ext;
    xfer_addr = {q.ir[12], q.ir[10:8]};
    alu_addr  = q.ir[3:0];
    mux_sel   = q.ir[13:10];
    test_vec  = test_in;
    test_vec[fms_pkg::MUX_ZERO]     = q.zero;
    test_vec[fms_pkg::MUX_TAPE_END] = tape_end_test_input;
    is_branch = (op == fms_pkg::OP_JUMP) || (op == fms_pkg::OP_CALL);
    // The always select bypasses the multiplexer entirely.
    taken = exec && ((is_branch && (mux_sel == fms_pkg::SEL_ALWAYS
                                    || test_vec[mux_sel]))
                     || op == fms_pkg::OP_RET);
    alu_class = (op == fms_pkg::OP_TEST) || (op == fms_pkg::OP_ALU_IMM)
                || (op == fms_pkg::OP_IN_FMT) || (op == fms_pkg::OP_IN_SCR);
    to_fmt = (op == fms_pkg::OP_IMM_FMT) || (op == fms_pkg::OP_ACC_FMT);
    case (op)
      fms_pkg::OP_IMM_FMT, fms_pkg::OP_IMM_SCR,
      fms_pkg::OP_TEST, fms_pkg::OP_ALU_IMM: db = q.ir[7:0];
      fms_pkg::OP_ACC_FMT, fms_pkg::OP_ACC_SCR: db = q.acc;
      fms_pkg::OP_IN_FMT: db = fmt_in_data;
      fms_pkg::OP_IN_SCR: db = q.scr[alu_addr];
      default: db = '0;
    endcase
    tb_preset = exec && to_fmt && (xfer_addr == fms_pkg::OUT_TIMEBASE);
    in_hot = onehot16({1'b0, alu_addr[2:0]});
    in_strobe = (exec && op == fms_pkg::OP_IN_FMT) ? in_hot[7:0] : '0;
  end

  // The ALU sees the accumulator on A and the data bus on B.
  always_comb
  begin
    alu_if.a  = q.acc;
    alu_if.b  = db;
    alu_if.fn = fms_pkg::fms_alu_fn_t'(q.ir[fms_pkg::FN_LSB +: 3]);
  end

  always_comb
  begin
    d          = q;
    d.ostb     = '0;
    d.tb_tick  = 1'b0;
    d.ir       = rom_data;
    d.ir_pc    = q.pc;
    d.ir_vld   = 1'b1;
    d.load_jump_address_ext = taken;
    d.pc       = q.pc + 10'h001;
    if (taken)
    begin
      if (op == fms_pkg::OP_RET)
      begin
        d.pc = q.ret;
      end
      else
      begin
        d.pc = q.ir[fms_pkg::PC_W-1:0];
      end
      if (op == fms_pkg::OP_CALL)
      begin
        d.ret = q.ir_pc + 10'h001;
      end
    end
    if (exec)
    begin
      case (op)
        fms_pkg::OP_IMM_FMT, fms_pkg::OP_ACC_FMT:
        begin
          d.fdata = db;
          d.ostb  = onehot16(xfer_addr);
        end
        fms_pkg::OP_IMM_SCR, fms_pkg::OP_ACC_SCR:
        begin
          d.scr[xfer_addr] = db;
        end
        fms_pkg::OP_TEST:
        begin
          d.zero = alu_if.zero;
        end
        fms_pkg::OP_ALU_IMM, fms_pkg::OP_IN_FMT, fms_pkg::OP_IN_SCR:
        begin
          d.zero = alu_if.zero;
          d.acc  = alu_if.r;
        end
        default:
        begin
          d.zero = q.zero;
        end
      endcase
    end
    // Time base reloads its preset and ticks once per period.
    if (tb_preset)
    begin
      d.tb_pre = db;
      d.tb_cnt = db;
    end
    else if (q.tb_cnt == '0)
    begin
      d.tb_tick = 1'b1;
      d.tb_cnt  = q.tb_pre;
    end
    else
    begin
      d.tb_cnt = q.tb_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      q        <= '0;
      q.pc     <= fms_pkg::PC_RESET;
      q.acc    <= fms_pkg::ACC_RESET;
      q.tb_pre <= fms_pkg::TB_PRESET_10US;
      q.tb_cnt <= fms_pkg::TB_PRESET_10US;
    end
    else
    begin
      q <= d;
    end
  end

  always_comb
  begin
    rom_addr          = q.pc;
    fmt_data          = q.fdata;
    out_strobe        = q.ostb;
    load_jump_address = taken || q.load_jump_address_ext;
    zero_flag         = q.zero;
    acc_bits          = q.acc;
    timebase_tick     = q.tb_tick;
    delay_count       = {q.scr[fms_pkg::SCR_DLY_HI],
                         q.scr[fms_pkg::SCR_DLY_LO]};
    // Firmware keeps the masked write command byte in location zero.
    write_cmd_fwd = q.scr[fms_pkg::SCR_WRCMD][fms_pkg::WRCMD_FWD_BIT];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_reset_state: assert property ($rose(rstn) |->
    rom_addr == fms_pkg::PC_RESET && acc_bits == '0 && !zero_flag)
    else $error("State not cleared by reset.");

  a_pc_step: assert property (q.ir_vld && !taken |=>
    rom_addr == $past(rom_addr) + 10'h001)
    else $error("Program counter did not step by one.");

  a_jump_target: assert property (taken && is_branch |=>
    rom_addr == $past(q.ir[9:0]))
    else $error("Taken branch did not load its target.");

  a_branch_always: assert property
    (exec && is_branch && mux_sel == fms_pkg::SEL_ALWAYS |=>
    rom_addr == $past(q.ir[fms_pkg::PC_W-1:0]))
    else $error("Unconditional branch not taken.");

  a_call_save: assert property (taken && op == fms_pkg::OP_CALL
    |=> q.ret == $past(q.ir_pc) + 10'h001)
    else $error("Call did not save the return address.");

  a_return_load: assert property (exec && op == fms_pkg::OP_RET
    |=> rom_addr == $past(q.ret))
    else $error("Return did not reload the program counter.");

  a_load_jump_address_block: assert property (taken |=>
    load_jump_address && !exec ##1 exec)
    else $error("Jump pulse not extended over one blocked step.");

  a_zero_latch: assert property (exec && alu_class |=>
    zero_flag == ($past(alu_if.r) == '0))
    else $error("Zero flag not latched from the ALU result.");

  a_zero_detect: assert property (
    exec && alu_class && op != fms_pkg::OP_TEST |=>
    zero_flag == (acc_bits == '0))
    else $error("Zero detect disagrees with the result.");

  a_test_keep: assert property (exec && op == fms_pkg::OP_TEST
    |=> acc_bits == $past(acc_bits))
    else $error("Test variant changed the accumulator.");

  a_clear_acc: assert property (
    exec && alu_class && op != fms_pkg::OP_TEST &&
    alu_if.fn == fms_pkg::FN_CLR |=> acc_bits == '0)
    else $error("Clear did not zero the accumulator.");

  a_out_strobe: assert property (exec && to_fmt |=>
    out_strobe == onehot16($past(xfer_addr)) && fmt_data == $past(db)
    ##1 out_strobe == '0 || $past(exec && to_fmt))
    else $error("Output strobe or data wrong.");

  a_scr_write: assert property (exec && op == fms_pkg::OP_IMM_SCR
    |=> q.scr[$past(xfer_addr)] == $past(q.ir[7:0]))
    else $error("Immediate not written to scratch pad.");

  a_in_strobe: assert property (exec && op == fms_pkg::OP_IN_FMT
    |-> $onehot(in_strobe) && in_strobe[alu_addr[2:0]])
    else $error("Input strobe not selected.");

endmodule // fms_core

// File: fms_fmt_model.sv
// Purpose: Behavioural formatter datapath facing the core's strobes.
// Assumes: Strobes are one-hot and sampled on the rising clock edge.
// Notes:   An idle input bus shows the inverse of the last byte returned.
`timescale 1ns/1ps
module fms_fmt_model (
  // Clock and bookkeeping
  input  wire logic        clk,
  input  wire logic        clr,
  // Core side
  input  wire logic [15:0] out_strobe,
  input  wire logic [7:0]  fmt_data,
  input  wire logic [7:0]  in_strobe,
  output logic [7:0]       fmt_in_data,
  // Observation
  output logic [7:0]       out_val [16],
  output logic [7:0]       out_cnt [16]
);
  logic [7:0] last_q = 8'h00;

  // The write command byte has its unused top bits set so masking shows.
  always @*
  begin
    fmt_in_data = ~last_q;
    for (int i = 0; i < 8; i++)
      if (in_strobe[i])
        fmt_in_data = (i == 7) ? 8'he5 : (8'ha0 | 8'(i));
  end

  always @(posedge clk)
  begin
    if (|in_strobe)
      last_q <= fmt_in_data;
    for (int i = 0; i < 16; i++)
      if (clr)
      begin
        out_cnt[i] <= 8'h00;
        out_val[i] <= 8'h00;
      end
      else if (out_strobe[i])
      begin
        out_cnt[i] <= out_cnt[i] + 8'h01;
        out_val[i] <= fmt_data;
      end
  end
endmodule // fms_fmt_model

// File: tb_fms_core.sv
// Purpose: Self-checking bench for the microsequencer core.
// Assumes: Program ROM is a bench array read combinationally.
// Notes:   Each row runs a short program between a clear and a jump-to-self.
`timescale 1ns/1ps
module tb_fms_core;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        clr = 1'b1;
  logic [15:0] rom [1024] = '{default: 16'h0000};
  logic [15:0] rom_data;
  logic [9:0]  rom_addr;
  logic [7:0]  fmt_data;
  logic [15:0] out_strobe;
  logic [7:0]  in_strobe;
  logic [7:0]  fmt_in_data;
  logic [15:0] test_in = 16'h0000;
  logic        tape_end = 1'b0;
  logic        lja;
  logic        zero_flag;
  logic [7:0]  acc_bits;
  logic        tick;
  logic [15:0] delay_count;
  logic        fwd;
  logic [7:0]  out_val [16];
  logic [7:0]  out_cnt [16];
  int          fails = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          n1;
  int          n2;
  // Rows: w1 w2 w3, acc, zero, delay count, forward bit.
  logic [79:0] rows [6] = '{
    80'h413f_5207_2800_25_0_0000_1, 80'h4155_43ff_4401_ab_0_0000_0,
    80'h4110_4510_4600_00_1_0000_0, 80'h4147_4700_0200_ff_1_0000_0,
    80'h6905_6a07_5901_05_0_0705_0, 80'h5103_4300_4300_a3_0_0000_0};

  always #50 clk = ~clk;
  assign rom_data = rom[rom_addr];

  fms_core dut_u (
    .clk                 (clk),
    .rstn                (rstn),
    .rom_addr            (rom_addr),
    .rom_data            (rom_data),
    .fmt_data            (fmt_data),
    .out_strobe          (out_strobe),
    .in_strobe           (in_strobe),
    .fmt_in_data         (fmt_in_data),
    .test_in             (test_in),
    .tape_end_test_input (tape_end),
    .load_jump_address   (lja),
    .zero_flag           (zero_flag),
    .acc_bits            (acc_bits),
    .timebase_tick       (tick),
    .delay_count         (delay_count),
    .write_cmd_fwd       (fwd)
  );

  fms_fmt_model fmt_u (
    .clk         (clk),
    .clr         (clr),
    .out_strobe  (out_strobe),
    .fmt_data    (fmt_data),
    .in_strobe   (in_strobe),
    .fmt_in_data (fmt_in_data),
    .out_val     (out_val),
    .out_cnt     (out_cnt)
  );

  task automatic complete_run();
    if (fails == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  // Reset, load words 0..7, check the reset state and release.
  task automatic go(input logic [127:0] w);
    rstn = 1'b0;
    clr = 1'b1;
    for (int i = 0; i < 8; i++)
      rom[i] = w[127-16*i -: 16];
    cyc(2);
    check("pc_rst", 16'(rom_addr), 16'h0000);
    check("acc_rst", 16'(acc_bits), 16'h0000);
    check("zero_rst", 16'(zero_flag), 16'h0000);
    check("strobe_rst", out_strobe, 16'h0000);
    rstn = 1'b1;
    clr = 1'b0;
  endtask

  task automatic tick_gap(output int n);
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 400)
    begin
      cyc(1);
      k++;
    end
    cyc(1);
    n = 1;
    while (tick !== 1'b1 && n < 400)
    begin
      cyc(1);
      n++;
    end
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      complete_run();
    end
  end

  initial
  begin
    cyc(8);
    foreach (rows[i])
    begin
      go({16'h4000, rows[i][79:32], 16'hbc04, 48'h0});
      cyc(10);
      check("acc", 16'(acc_bits), 16'(rows[i][31:24]));
      check("zero", 16'(zero_flag), 16'(rows[i][20]));
      check("dly", delay_count, rows[i][19:4]);
      check("fwd", 16'(fwd), 16'(rows[i][0]));
    end
    go({16'hbc00, 112'h0});
    tick_gap(n1);
    go({16'h415a, 16'h2300, 16'h7410, 16'hbc03, 64'h0});
    cyc(4);
    tick_gap(n2);
    check("gap_diff", 16'(n1 - n2), 16'h00c0);
    check("gap16", 16'(n2 == 16 || n2 == 17), 16'h0001);
    check("acc_out", 16'(out_val[3]), 16'h005a);
    check("imm_out", 16'(out_val[12]), 16'h0010);
    check("pulse_cnt", 16'(out_cnt[12]), 16'h0001);
    check("bus_hold", 16'(fmt_data), 16'h0010);
    rom[8] = 16'h62bb;
    rom[9] = 16'hbc09;
    rom[20] = 16'ha81e;
    rom[21] = 16'h61aa;
    rom[22] = 16'h1000;
    rom[30] = 16'h1000;
    for (int te = 0; te < 2; te++)
    begin
      tape_end = te[0];
      go({16'h4000, 16'h8005, 16'h61aa, 32'h0, 16'h4101, 16'h8009,
          16'hfc14});
      cyc(30);
      check("skip_cnt", 16'(out_cnt[1]), 16'(1 - te));
      check("ret_cnt", 16'(out_cnt[2]), 16'h0001);
      check("loop_pc", 16'(rom_addr >= 10'h009 && rom_addr <= 10'h00a),
            16'h0001);
      check("lja", 16'(lja), 16'h0001);
      cyc(1);
      check("lja_next", 16'(lja), 16'h0001);
      // A conditional jump on a plain test input skips the output.
      test_in[5] = te[0];
      go({16'h9403, 16'h61aa, 16'h0000, 16'hbc03, 64'h0});
      cyc(8);
      check("mux_in", 16'(out_cnt[1]), 16'(1 - te));
    end
    complete_run();
  end
endmodule // tb_fms_core
